// ---- inc/stx_pkg.sv ----
// Package for the serial transmit clock and output-enable block.
// Assumes a single system clock; all slower rates are enable pulses.
package stx_pkg;
  // Character width and bit-slot timing
  localparam int          CHAR_BITS   = 10;        // Bits per transmission character
  localparam int          BIT_CNT_W   = 4;         // Width of the bit-slot counter
  localparam logic [3:0]  LAST_SLOT   = 4'h9;      // Final bit slot of a character
  localparam logic [3:0]  READ_SLOT   = 4'h5;      // Slot where the read strobe goes high
  // Sync character, running-disparity-negative form of K28.5
  localparam logic [9:0]  SYNC_CHAR   = 10'h0fa;   // Sent when no data is enabled
  localparam logic [9:0]  RESET_CHAR  = 10'h000;   // Shifter contents out of reset
  // Transmitter-off source selections
  typedef enum logic [1:0] {
    OFF_SRC_NONE,                                  // No jumper: pairs one, two disabled
    OFF_SRC_LINK,                                  // Connector link-control signal
    OFF_SRC_SWITCH                                 // Switch or its mirrored connector pin
  } stx_offsrc_type;
  // One differential serial pair
  typedef struct packed {
    logic pos;                                     // True leg
    logic neg;                                     // Complement leg
  } stx_pair_type;
  // Load enables sampled each character period (both active low)
  typedef struct packed {
    logic immLoadN;                                // Immediate load enable
    logic nextLoadN;                               // Next-cycle load enable
  } stx_enables_type;
endpackage : stx_pkg

// ---- rtl/stx_char_reg.sv ----
// Ten-bit character holding register with synchronous load.
// Assumes the caller qualifies the load with its own character strobe.
`timescale 1ns/1ps
`default_nettype none
module stx_char_reg #(
  parameter int WIDTH = 10                         // Character width
) (
  input  wire logic             clock,             // System clock
  input  wire logic             rst_n,             // Synchronous reset, active low
  input  wire logic             load,              // Capture strobe
  input  wire logic [WIDTH-1:0] dataIn,            // Word to capture
  output logic      [WIDTH-1:0] dataOut            // Registered word
);
  // Holding register, cleared on reset
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      dataOut <= '0;
    end else if (load) begin
      dataOut <= dataIn;
    end
  end
endmodule : stx_char_reg
`default_nettype wire

// ---- rtl/stx_tx_ctrl.sv ----
// Transmit control: load clock selection, character shifter, read strobe,
// serial pair gating and receiver input select.
// Assumes every input is synchronous to clock; the load clock is an enable.
//
// Summary of operation
// - All work on system clock rising edge
// - Shifter and read strobe derive from load clock
// - Load clock from oscillator or external input
// - Read strobe phased for data at next edge
// - Read strobe only when immediate enable low
// - Three pairs carry identical shifter stream while on
// - Transmitter off forces pairs one, two to zero
// - Transmitter on lets pairs one, two follow
// - Loopback pair always follows shifter
// - Transmitter off from one configured source
// - No source selected disables pairs one, two
// - Receiver uses exactly one input pair
// - Select high line pair, low loopback
// - Load data or send sync per enables
`timescale 1ns/1ps
`default_nettype none
module stx_tx_ctrl
  import stx_pkg::*;
#(
  parameter int CHAR_W = CHAR_BITS                 // Character width
) (
  input  wire logic            clock,              // System clock, bit rate
  input  wire logic            rst_n,              // Synchronous reset, active low
  input  wire logic            oscTick,            // On-board oscillator load tick
  input  wire logic            extTxClockIn,       // External transmit clock tick
  input  wire logic            useExtClock,        // Static clock-source choice
  input  wire stx_enables_type loadEnables,        // Active-low load enables
  input  wire logic [CHAR_W-1:0] txData,           // Parallel character bus
  input  wire stx_offsrc_type  offSource,          // Transmitter-off source jumper
  input  wire logic            linkControl,        // Connector link-control level
  input  wire logic            switchTxDisable,    // Switch/mirrored disable level
  input  wire logic            rxInputSelect,      // High: line pair, low: loopback
  input  wire stx_pair_type    rxLineInputPair,    // Receiver line input pair
  input  wire stx_pair_type    rxAlternateInputPair, // Receiver loopback input
  output stx_pair_type         firstSerialPair,    // Gated output pair one
  output stx_pair_type         secondSerialPair,   // Gated output pair two
  output stx_pair_type         loopbackSerialPair, // Ungated loopback pair
  output logic                 fifoReadPulseN,     // FIFO read strobe, active low
  output logic                 rxSerialBit,        // Selected receiver serial bit
  output logic                 charLoadTick,       // Character boundary marker
  output logic                 transmitterOff_q    // Effective off state
);

  // Bit-slot counter and state
  logic [BIT_CNT_W-1:0] slot_q;                    // Current bit slot
  logic [CHAR_W-1:0]    shift_q;                   // Serial shifter
  logic [CHAR_W-1:0]    heldChar;                  // Character from holding register
  logic [CHAR_W-1:0]    charSel_d;                 // Character chosen for next load
  logic                 nextLoad_q;                // Earlier next-cycle enable was low
  logic                 loadEdge;                  // Selected load clock tick
  logic                 offLevel;                  // Resolved transmitter-off level
  logic                 serialBit;                 // Bit leaving the shifter

  // The load tick is the one clock source picked by a static setting;
  // mixing both would double the character rate.
  assign loadEdge = useExtClock ? extTxClockIn : oscTick;

  // Slot counter restarts on every load tick, so one character per period
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      slot_q <= '0;
    end else if (loadEdge) begin
      slot_q <= '0;
    end else if (slot_q != LAST_SLOT) begin
      slot_q <= slot_q + 4'h1;
    end
  end

  // Choose data or sync for this load edge
  always_comb begin
    charSel_d = SYNC_CHAR;
    if (!loadEnables.immLoadN || nextLoad_q) begin
      charSel_d = txData;
    end
  end

  // Next-cycle enable remembered until the following load edge
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      nextLoad_q <= 1'b0;
    end else if (loadEdge) begin
      nextLoad_q <= !loadEnables.nextLoadN;
    end
  end

  // Holding register samples the bus only on the load edge
  stx_char_reg #(
    .WIDTH   (CHAR_W)
  ) uCharReg (
    .clock   (clock),
    .rst_n   (rst_n),
    .load    (loadEdge),
    .dataIn  (charSel_d),
    .dataOut (heldChar)
  );

  // Shifter reloads one slot after the edge, then shifts LSB first
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      shift_q <= RESET_CHAR;
    end else if (slot_q == '0) begin
      shift_q <= heldChar;
    end else begin
      shift_q <= {1'b0, shift_q[CHAR_W-1:1]};
    end
  end
  assign serialBit = shift_q[0];

  // Read strobe low for the first six cycles of the period, only when the
  // immediate enable is low, so the FIFO word settles before the next edge.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      fifoReadPulseN <= 1'b1;
    end else if (loadEdge) begin
      fifoReadPulseN <= loadEnables.immLoadN;
    end else if (slot_q == READ_SLOT) begin
      fifoReadPulseN <= 1'b1;
    end
  end

  // Resolve the off control from exactly one jumper source
  always_comb begin
    unique case (offSource)
      OFF_SRC_LINK:   offLevel = linkControl;
      OFF_SRC_SWITCH: offLevel = switchTxDisable;
      default:        offLevel = 1'b1;
    endcase
  end

  // Registered off state
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      transmitterOff_q <= 1'b1;
    end else begin
      transmitterOff_q <= offLevel;
    end
  end

  // Differential form of one bit; a zero is true leg low, complement high
  function automatic stx_pair_type pairOf(input logic bitVal);
    return '{pos: bitVal, neg: !bitVal};
  endfunction : pairOf

  // Output pairs; gated pairs hold a static zero while off
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      firstSerialPair    <= pairOf(1'b0);
      secondSerialPair   <= pairOf(1'b0);
      loopbackSerialPair <= pairOf(1'b0);
    end else begin
      loopbackSerialPair <= pairOf(serialBit);
      if (offLevel) begin
        firstSerialPair  <= pairOf(1'b0);
        secondSerialPair <= pairOf(1'b0);
      end else begin
        firstSerialPair  <= pairOf(serialBit);
        secondSerialPair <= pairOf(serialBit);
      end
    end
  end

  // Receiver input mux: one pair only
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rxSerialBit <= 1'b0;
    end else if (rxInputSelect) begin
      rxSerialBit <= rxLineInputPair.pos;
    end else begin
      rxSerialBit <= rxAlternateInputPair.pos;
    end
  end

  // Boundary marker for observers
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      charLoadTick <= 1'b0;
    end else begin
      charLoadTick <= loadEdge;
    end
  end

  // Read strobe follows the immediate enable at the load edge
  a_read_pulse_en: assert property (@(posedge clock) disable iff (!rst_n)
    loadEdge |=> (fifoReadPulseN == $past(loadEnables.immLoadN)))
    else $error("read strobe does not match immediate enable");

  // Strobe may only fall right after a load edge with the immediate enable low
  a_read_pulse_cause: assert property (@(posedge clock) disable iff (!rst_n)
    $fell(fifoReadPulseN) |-> $past(loadEdge && !loadEnables.immLoadN))
    else $error("read strobe without immediate enable");

  // Strobe stays low for six cycles, rising at the read slot
  a_read_pulse_width: assert property (@(posedge clock) disable iff (!rst_n)
    $fell(fifoReadPulseN) |-> !fifoReadPulseN [*6] ##1 fifoReadPulseN)
    else $error("read strobe width wrong");

  // Off forces first pair to zero
  a_off_forces_zero: assert property (@(posedge clock) disable iff (!rst_n)
    offLevel |=> (!firstSerialPair.pos && firstSerialPair.neg && !secondSerialPair.pos))
    else $error("gated pair not zero while off");

  // On lets pair one follow the shifter
  a_on_follows: assert property (@(posedge clock) disable iff (!rst_n)
    !offLevel |=> (firstSerialPair.pos == $past(serialBit)))
    else $error("gated pair not following shifter");

  // Loopback pair always follows
  a_loop_follows: assert property (@(posedge clock) disable iff (!rst_n)
    1'b1 |=> (loopbackSerialPair.pos == $past(serialBit)
              && loopbackSerialPair.neg != loopbackSerialPair.pos))
    else $error("loopback pair not following shifter");

  // Pairs carry identical stream when on
  a_pairs_equal: assert property (@(posedge clock) disable iff (!rst_n)
    $past(!offLevel) |-> (firstSerialPair == loopbackSerialPair
                          && secondSerialPair == loopbackSerialPair))
    else $error("serial pairs differ");

  // No source means disabled
  a_no_source_off: assert property (@(posedge clock) disable iff (!rst_n)
    (offSource == OFF_SRC_NONE) |=> transmitterOff_q)
    else $error("outputs enabled with no source");

  // Sync sent when immediate enable high and no pending next load
  a_sync_char: assert property (@(posedge clock) disable iff (!rst_n)
    (loadEdge && loadEnables.immLoadN && !nextLoad_q) |=> (heldChar == SYNC_CHAR))
    else $error("sync character not loaded");

  // Shifter reload one slot after each edge
  a_char_reload: assert property (@(posedge clock) disable iff (!rst_n)
    loadEdge ##1 1'b1 |=> (shift_q == $past(heldChar)))
    else $error("shifter not reloaded");

  // Receiver select
  a_rx_select: assert property (@(posedge clock) disable iff (!rst_n)
    !rxInputSelect |=> (rxSerialBit == $past(rxAlternateInputPair.pos)))
    else $error("receiver not on loopback input");

endmodule : stx_tx_ctrl
`default_nettype wire

// ---- verif/stx_fifo_model.sv ----
// Behavioural FIFO that feeds the transmit character bus.
// Assumes the read strobe is active low; one strobe is one read.
`timescale 1ns/1ps
`default_nettype none
module stx_fifo_model
  import stx_pkg::*;
(
  input  wire logic                 clock,          // System clock
  input  wire logic                 rst_n,          // Sync reset, active low
  input  wire logic                 fifoReadPulseN, // Read strobe
  output logic      [CHAR_BITS-1:0] fifoWord        // Word on the bus
);
  logic strobePrev_q;  // Strobe level one cycle back
  // Next word appears as the strobe ends, well before the next load tick
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      fifoWord     <= 10'h1a5;
      strobePrev_q <= 1'b1;
    end else begin
      strobePrev_q <= fifoReadPulseN;
      if (fifoReadPulseN && !strobePrev_q) begin
        fifoWord <= {fifoWord[8:0], fifoWord[9] ^ fifoWord[6]};
      end
    end
  end
endmodule : stx_fifo_model
`default_nettype wire

// ---- verif/tb_stx_tx_ctrl.sv ----
// Self-checking bench for the transmit control block.
// Assumes ticks every 10 cycles; loopback pair feeds the receiver.
`timescale 1ns/1ps
`default_nettype none
module tb_stx_tx_ctrl;
  import stx_pkg::*;
  logic            clock = 1'b0, rst_n = 1'b0;  // Clock and reset
  logic            oscTick = 1'b0, extTick = 1'b0, useExt = 1'b0;
  stx_enables_type le = 2'h3;                   // Load enables
  stx_offsrc_type  offSrc = OFF_SRC_NONE;       // Off source jumper
  logic            linkCtl = 1'b0, swDis = 1'b0, rxSel = 1'b0;
  stx_pair_type    linePair = 2'h1;             // Line input
  stx_pair_type    pairA, pairB, pairC;         // Serial outputs
  logic            readN, rxBit, cltk, offQ;    // Other outputs
  logic      [9:0] word;                        // FIFO bus
  logic     [15:0] lfsr = 16'h32a9;             // Random state, 12969
  logic      [9:0] charQ[$];                    // Expected characters
  logic            immQ[$];                     // Expected strobe level
  int              nErrors = 0, totalChecks = 0;
  always #50 clock = ~clock;
  stx_tx_ctrl dut_u (.clock(clock), .rst_n(rst_n), .oscTick(oscTick),
    .extTxClockIn(extTick), .useExtClock(useExt), .loadEnables(le), .txData(word),
    .offSource(offSrc), .linkControl(linkCtl), .switchTxDisable(swDis),
    .rxInputSelect(rxSel), .rxLineInputPair(linePair), .rxAlternateInputPair(pairC),
    .firstSerialPair(pairA), .secondSerialPair(pairB), .loopbackSerialPair(pairC),
    .fifoReadPulseN(readN), .rxSerialBit(rxBit), .charLoadTick(cltk),
    .transmitterOff_q(offQ));
  stx_fifo_model fifo_u (.clock(clock), .rst_n(rst_n), .fifoReadPulseN(readN),
    .fifoWord(word));
  // Sixteen-bit shift register for repeatable stimulus
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_next
  // One comparison, counted
  task automatic check(input string what, input logic [10:0] seen, exp);
    totalChecks++;
    if (seen !== exp) begin
      nErrors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // Sole exit of the run
  task automatic giveVerdict();
    $display("checks %0d errors %0d", totalChecks, nErrors);
    if (nErrors == 0 && totalChecks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : giveVerdict
  // Watchdog, about three times the expected run
  initial begin
    repeat (2000) @(posedge clock);
    nErrors++;
    giveVerdict();
  end
  // Stimulus: one selected tick per 10 cycles, unselected source off-phase
  initial begin
    logic prevNext;
    prevNext = 1'b1;
    repeat (16) @(posedge clock);
    @(negedge clock);
    check("reset pair", pairA, 2'h1);
    check("reset strobe", readN, 1'b1);
    check("reset off", offQ, 1'b1);
    @(posedge clock) rst_n <= 1'b1;
    for (int t = 0; t < 60; t++) begin
      for (int k = 0; k < 10; k++) begin
        @(posedge clock);
        lfsr = lfsr_next(lfsr);
        linePair <= {lfsr[7], ~lfsr[7]};
        if (k == 0) begin  // Load tick: note what must go out
          if (useExt) extTick <= 1'b1;
          else oscTick <= 1'b1;
          charQ.push_back((!le.immLoadN || !prevNext) ? word : SYNC_CHAR);
          immQ.push_back(le.immLoadN);
          prevNext = le.nextLoadN;
        end else if (k == 4) begin  // Wrong source pulses; new settings
          if (useExt) oscTick <= 1'b1;
          else extTick <= 1'b1;
          le      <= lfsr[1:0];
          offSrc  <= stx_offsrc_type'(lfsr[3:2]);
          linkCtl <= lfsr[4];
          swDis   <= lfsr[5];
          rxSel   <= lfsr[6];
        end else begin
          oscTick <= 1'b0;
          extTick <= 1'b0;
        end
        if (t == 30 && k == 7) useExt <= 1'b1;  // Static source swap
      end
    end
    repeat (30) @(posedge clock);
    check("notes left", 11'(charQ.size()), 11'h0);
    giveVerdict();
  end
  // Monitor: outputs seen at a negedge reflect inputs of the edge before
  logic [9:0]  bits = 10'h0;   // Last ten loopback bits, LSB first
  logic [11:0] pend = 12'h0;   // Character boundary history
  logic        offHist = 1'b1, rxHist = 1'b0, rstHist = 1'b0;
  always @(negedge clock) begin
    if (rstHist) begin
      check("pair C legs", pairC.neg, !pairC.pos);
      check("pair A", pairA, offHist ? 2'h1 : pairC);
      check("pair B", pairB, offHist ? 2'h1 : pairC);
      check("off level", offQ, offHist);
      check("rx bit", rxBit, rxHist);
      if (cltk === 1'b1 && immQ.size() > 0)
        check("read strobe", readN, immQ.pop_front());
      bits = {pairC.pos, bits[9:1]};
      pend = {pend[10:0], cltk === 1'b1};
      if (pend[11] && charQ.size() > 0)
        check("character", bits, charQ.pop_front());
    end
    if (offSrc == OFF_SRC_LINK) offHist = linkCtl;
    else if (offSrc == OFF_SRC_SWITCH) offHist = swDis;
    else offHist = 1'b1;
    rxHist  = rxSel ? linePair.pos : pairC.pos;
    rstHist = rst_n;
  end
endmodule : tb_stx_tx_ctrl
`default_nettype wire
